// ===== hdl/isc_port.v
// Operation
// (R1) Mode select on C0, clock C1, data-in C5, data-out C6.
// (R2) Serial port pins work on a blank device with no setup.
// (R3) After power-up all serial pins are inputs awaiting the enable command.
// (R4) Data-out is driven only after the enable command is taken.
// (R5) Enable command optionally turns on busy and error extension outputs.
// (R6) Outside controller holds chip reset low while programming.
// (R7) Only configuration commands exist; boundary scan codes act as bypass.
// (R8) Error output goes low when erase or byte program fails.
// (R9) Error stays low until clear command, or chip reset after disable.
// (R10) Busy status output high while flash is in read mode.
// (R11) Busy status low during program, erase or secondary write.
// (R12) Enable command may select open-drain drive for both extensions.
// (R13) With security set, every content read is refused.
// (R14) With security set, only full chip erase is accepted.
// (R15) Full chip erase clears security, leaving a blank unsecured part.
// (R16) Erase of a protected sector is refused.
// (R17) A delivered part reads all ones everywhere.
// (R18) Before enable, data-out and extensions stay undriven.
`timescale 1ns/1ns
`default_nettype none
`include "isc_port_defines.vh"

module isc_port #(
  parameter PRI_SECTORS = `PRI_SECTORS,
  parameter SEC_SECTORS = `SEC_SECTORS
) (
  input wire clock_in, // 125 MHz system clock
  input wire reset_n_in, // Async reset, active low
  input wire pc0_tms_in, // Mode select pin
  input wire pc1_tck_in, // Serial clock pin
  input wire pc5_tdi_in, // Serial data in pin
  output reg pc6_tdo_out, // Serial data out level
  output reg pc6_tdo_oe_out, // Serial data out enable
  output reg pc3_status_out, // flash_busy_status_out level
  output reg pc3_status_oe_out, // flash_busy_status_out enable
  output reg pc4_error_out, // flash_error_flag_out level
  output reg pc4_error_oe_out, // flash_error_flag_out enable
  input wire chip_reset_n_in, // Chip reset pin, active low
  input wire security_bit_in, // Security bit is set
  input wire [PRI_SECTORS-1:0] pri_protect_in, // Primary sector protect bits
  input wire [SEC_SECTORS-1:0] sec_protect_in, // Secondary sector protect bits
  input wire flash_busy_in, // Flash engine cycle in progress
  input wire sec_write_in, // Secondary flash being written
  input wire flash_done_in, // Flash operation finished, pulse
  input wire flash_fail_in, // Finished operation failed
  input wire [`DATA_W-1:0] flash_rdata_in, // Read data valid with done
  output reg flash_start_out, // Start operation, pulse
  output reg [`OP_W-1:0] flash_op_out, // Operation code
  output reg flash_sec_out, // Target is secondary flash
  output reg [`ADDR_W-1:0] flash_addr_out, // Target address
  output reg [`DATA_W-1:0] flash_wdata_out, // Byte to program
  output reg security_clear_out // Clear security bit, pulse
);

  // ==========================================================
  // TAP states
  localparam [15:0] S_TLR = 16'h0001;
  localparam [15:0] S_RTI = 16'h0002;
  localparam [15:0] S_SELDR = 16'h0004;
  localparam [15:0] S_CAPDR = 16'h0008;
  localparam [15:0] S_SHDR = 16'h0010;
  localparam [15:0] S_EX1DR = 16'h0020;
  localparam [15:0] S_PAUDR = 16'h0040;
  localparam [15:0] S_EX2DR = 16'h0080;
  localparam [15:0] S_UPDR = 16'h0100;
  localparam [15:0] S_SELIR = 16'h0200;
  localparam [15:0] S_CAPIR = 16'h0400;
  localparam [15:0] S_SHIR = 16'h0800;
  localparam [15:0] S_EX1IR = 16'h1000;
  localparam [15:0] S_PAUIR = 16'h2000;
  localparam [15:0] S_EX2IR = 16'h4000;
  localparam [15:0] S_UPIR = 16'h8000;

  // ==========================================================
  // Pin synchronisers and edge detection
  wire [3:0] pins_s;
  reg tck_d_r;
  reg rst_d_r;

  pin_sync #(.WIDTH(4)) u_sync (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .async_in({chip_reset_n_in, pc5_tdi_in, pc1_tck_in, pc0_tms_in}), // R1
    .sync_out(pins_s)
  );

  wire tms_s = pins_s[0];
  wire tck_s = pins_s[1];
  wire tdi_s = pins_s[2];
  wire crst_s = pins_s[3];
  wire tck_rise = tck_s & ~tck_d_r;
  wire tck_fall = ~tck_s & tck_d_r;
  // Only honoured after a disable, so a stray edge while the synchroniser fills is harmless
  wire crst_rise = crst_s & ~rst_d_r;

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tck_d_r <= 1'b0;
      rst_d_r <= 1'b1;
    end else begin
      tck_d_r <= tck_s;
      rst_d_r <= crst_s;
    end
  end

  // ==========================================================
  // TAP controller, stepped on each serial clock rise
  reg [15:0] state_r;
  reg [15:0] state_nxt;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_TLR: state_nxt = tms_s ? S_TLR : S_RTI;
      S_RTI: state_nxt = tms_s ? S_SELDR : S_RTI;
      S_SELDR: state_nxt = tms_s ? S_SELIR : S_CAPDR;
      S_CAPDR: state_nxt = tms_s ? S_EX1DR : S_SHDR;
      S_SHDR: state_nxt = tms_s ? S_EX1DR : S_SHDR;
      S_EX1DR: state_nxt = tms_s ? S_UPDR : S_PAUDR;
      S_PAUDR: state_nxt = tms_s ? S_EX2DR : S_PAUDR;
      S_EX2DR: state_nxt = tms_s ? S_UPDR : S_SHDR;
      S_UPDR: state_nxt = tms_s ? S_SELDR : S_RTI;
      S_SELIR: state_nxt = tms_s ? S_TLR : S_CAPIR;
      S_CAPIR: state_nxt = tms_s ? S_EX1IR : S_SHIR;
      S_SHIR: state_nxt = tms_s ? S_EX1IR : S_SHIR;
      S_EX1IR: state_nxt = tms_s ? S_UPIR : S_PAUIR;
      S_PAUIR: state_nxt = tms_s ? S_EX2IR : S_PAUIR;
      S_EX2IR: state_nxt = tms_s ? S_UPIR : S_SHIR;
      S_UPIR: state_nxt = tms_s ? S_SELDR : S_RTI;
      default: state_nxt = S_TLR;
    endcase
  end

  // Port is live straight out of reset; no configuration gates it
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= S_TLR; // R2
    end else if (tck_rise) begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Instruction decode
  reg [`IR_W-1:0] ir_r;
  reg [`IR_W-1:0] ir_sh_r;
  wire upd_dr = tck_rise & (state_r == S_UPDR);
  wire upd_ir = tck_rise & (state_r == S_UPIR);
  wire cap_dr = tck_rise & (state_r == S_CAPDR);
  wire sh_dr = tck_rise & (state_r == S_SHDR);

  wire i_enable = (ir_r == `INS_ENABLE);
  wire i_prog = (ir_r == `INS_PROGRAM);
  wire i_sect = (ir_r == `INS_ERASE_SECTOR);
  wire i_chip = (ir_r == `INS_CHIP_ERASE);
  wire i_read = (ir_r == `INS_READ);
  // Unknown codes, boundary scan ones included, fall through to bypass
  wire i_access = i_prog | i_sect | i_chip | i_read; // R7
  // Disable and clear take effect from the freshly shifted code at Update-IR
  wire new_disable = (ir_sh_r == `INS_DISABLE);
  wire new_clear = (ir_sh_r == `INS_CLEAR);

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ir_r <= `INS_BYPASS;
      ir_sh_r <= `INS_BYPASS;
    end else if (tck_rise) begin
      // Test-Logic-Reset falls back to bypass but leaves the channel open
      if (state_r == S_TLR) begin
        ir_r <= `INS_BYPASS;
      end else if (state_r == S_CAPIR) begin
        ir_sh_r <= `IR_CAPTURE;
      end else if (state_r == S_SHIR) begin
        ir_sh_r <= {tdi_s, ir_sh_r[`IR_W-1:1]};
      end else if (state_r == S_UPIR) begin
        ir_r <= ir_sh_r;
      end
    end
  end

  // ==========================================================
  // Data registers
  reg byp_r;
  reg [`OPT_W-1:0] opt_sh_r;
  reg [`DR_W-1:0] dr_sh_r;
  reg [`DATA_W-1:0] rdata_r;
  // Only the selected register shifts; the bypass bit follows data-in regardless

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      byp_r <= 1'b0;
      opt_sh_r <= {`OPT_W{1'b0}};
      dr_sh_r <= {`DR_W{1'b0}};
    end else if (cap_dr) begin
      byp_r <= 1'b0;
      dr_sh_r[`DR_DATA_HI:`DR_DATA_LO] <= rdata_r;
    end else if (sh_dr) begin
      byp_r <= tdi_s;
      if (i_enable) begin
        opt_sh_r <= {tdi_s, opt_sh_r[`OPT_W-1:1]};
      end
      if (i_access) begin
        dr_sh_r <= {tdi_s, dr_sh_r[`DR_W-1:1]};
      end
    end
  end

  // ==========================================================
  // Channel enable and extension options
  reg enabled_r;
  reg ext_en_r;
  reg od_r;
  reg disabled_r;
  // Disable drops the pins but leaves the error flag for a chip reset release

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      enabled_r <= 1'b0; // R3
      ext_en_r <= 1'b0;
      od_r <= 1'b0;
      disabled_r <= 1'b0;
    end else if (upd_dr && i_enable) begin
      enabled_r <= 1'b1; // R4
      ext_en_r <= opt_sh_r[`OPT_EXT_BIT]; // R5
      od_r <= opt_sh_r[`OPT_OD_BIT]; // R12
      disabled_r <= 1'b0;
    end else if (upd_ir && new_disable) begin
      enabled_r <= 1'b0;
      ext_en_r <= 1'b0;
      disabled_r <= 1'b1;
    end
  end

  // ==========================================================
  // Command checks and flash sequencing
  wire dr_sec = dr_sh_r[`DR_SEC_BIT];
  wire [`ADDR_W-1:0] dr_addr = dr_sh_r[`DR_ADDR_HI:`DR_ADDR_LO];
  wire [2:0] pri_idx = dr_addr[`PRI_SECT_HI:`PRI_SECT_LO];
  wire [1:0] sec_idx = dr_addr[`SEC_SECT_HI:`SEC_SECT_LO];
  wire sect_prot = dr_sec ? sec_protect_in[sec_idx] : pri_protect_in[pri_idx];
  // Secured part takes only chip erase; sector erase of a protected sector is refused
  wire blocked = (security_bit_in & ~i_chip) | (i_sect & sect_prot); // R14 R16
  // One operation at a time; an update that lands while one is pending is dropped, not queued
  reg pending_r;
  reg [`OP_W-1:0] op_r;
  wire go = upd_dr & i_access & enabled_r & ~pending_r;
  // Refused writes raise the error flag; a refused read just returns a fixed byte
  wire refused = go & blocked & ~i_read;
  wire failed = flash_done_in & pending_r & flash_fail_in & (op_r != `OP_READ); // R8

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pending_r <= 1'b0;
      op_r <= `OP_READ;
      flash_start_out <= 1'b0;
      flash_op_out <= `OP_READ;
      flash_sec_out <= 1'b0;
      flash_addr_out <= {`ADDR_W{1'b0}};
      flash_wdata_out <= {`DATA_W{1'b0}};
      security_clear_out <= 1'b0;
      rdata_r <= `BLANK_BYTE; // R17
    end else begin
      flash_start_out <= 1'b0;
      security_clear_out <= 1'b0;
      if (go && !blocked) begin
        pending_r <= 1'b1;
        flash_start_out <= 1'b1;
        flash_op_out <= i_read ? `OP_READ : i_prog ? `OP_PROGRAM :
                        i_sect ? `OP_SECTOR : `OP_CHIP;
        op_r <= i_read ? `OP_READ : i_prog ? `OP_PROGRAM :
                i_sect ? `OP_SECTOR : `OP_CHIP;
        flash_sec_out <= dr_sec;
        flash_addr_out <= dr_addr;
        flash_wdata_out <= dr_sh_r[`DR_DATA_HI:`DR_DATA_LO];
      end else if (go && i_read) begin
        rdata_r <= `SECURE_READ_BYTE; // R13
      end else if (pending_r && flash_done_in) begin
        pending_r <= 1'b0;
        if (op_r == `OP_READ) begin
          rdata_r <= flash_rdata_in;
        end
        if (op_r == `OP_CHIP && !flash_fail_in) begin
          security_clear_out <= 1'b1; // R15
        end
      end
    end
  end

  // ==========================================================
  // Error flag; a new failure outranks a clear in the same cycle
  reg err_r;
  // Controller keeps chip reset low during programming, so its release ends the session
  wire err_clr = (upd_ir & new_clear) | (disabled_r & crst_rise); // R6 R9

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      err_r <= 1'b0;
    end else if (failed || refused) begin
      err_r <= 1'b1; // R8
    end else if (err_clr) begin
      err_r <= 1'b0; // R9
    end
  end

  // ==========================================================
  // Pin drivers
  wire busy = pending_r | flash_busy_in | sec_write_in; // R11
  wire stat_lvl = ~busy; // R10
  wire err_lvl = ~err_r;
  // Pin levels are registered so decode hazards never reach the pins

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pc6_tdo_out <= 1'b0;
      pc6_tdo_oe_out <= 1'b0; // R18
      pc3_status_out <= 1'b0;
      pc3_status_oe_out <= 1'b0; // R18
      pc4_error_out <= 1'b0;
      pc4_error_oe_out <= 1'b0; // R18
    end else begin
      // Data out changes on the falling serial clock to meet the rising sample
      if (tck_fall) begin
        pc6_tdo_oe_out <= enabled_r & ((state_r == S_SHDR) | (state_r == S_SHIR)); // R4
        if (state_r == S_SHIR) begin
          pc6_tdo_out <= ir_sh_r[0];
        end else if (i_enable) begin
          pc6_tdo_out <= opt_sh_r[0];
        end else if (i_access) begin
          pc6_tdo_out <= dr_sh_r[0];
        end else begin
          pc6_tdo_out <= byp_r;
        end
      end
      // Open-drain mode only pulls low; otherwise both levels are driven
      pc3_status_out <= od_r ? 1'b0 : stat_lvl; // R12
      pc3_status_oe_out <= ext_en_r & (od_r ? ~stat_lvl : 1'b1); // R5
      pc4_error_out <= od_r ? 1'b0 : err_lvl; // R12
      pc4_error_oe_out <= ext_en_r & (od_r ? ~err_lvl : 1'b1); // R5
    end
  end

endmodule // isc_port

`default_nettype wire

// ===== hdl/isc_port_defines.vh
`ifndef ISC_PORT_DEFINES_VH
`define ISC_PORT_DEFINES_VH

// Instruction register
`define IR_W 8
`define IR_CAPTURE 8'h01
`define INS_BYPASS 8'hff
`define INS_ENABLE 8'h0c
`define INS_DISABLE 8'h0f
`define INS_CLEAR 8'h0d
`define INS_PROGRAM 8'h11
`define INS_ERASE_SECTOR 8'h12
`define INS_CHIP_ERASE 8'h13
`define INS_READ 8'h14

// Enable options register
`define OPT_W 8
`define OPT_EXT_BIT 0
`define OPT_OD_BIT 1

// Access register: [23] secondary, [22:8] address, [7:0] data
`define DR_W 24
`define DR_SEC_BIT 23
`define DR_ADDR_HI 22
`define DR_ADDR_LO 8
`define DR_DATA_HI 7
`define DR_DATA_LO 0
`define ADDR_W 15
`define DATA_W 8
`define PRI_SECT_HI 14
`define PRI_SECT_LO 12
`define SEC_SECT_HI 13
`define SEC_SECT_LO 12
`define PRI_SECTORS 8
`define SEC_SECTORS 4

// Flash operation codes
`define OP_W 2
`define OP_READ 2'h0
`define OP_PROGRAM 2'h1
`define OP_SECTOR 2'h2
`define OP_CHIP 2'h3

`define BLANK_BYTE 8'hff
`define SECURE_READ_BYTE 8'h00

`endif

// ===== hdl/pin_sync.v
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter WIDTH = 4
) (
  input wire clock_in, // System clock
  input wire reset_n_in, // Async reset, active low
  input wire [WIDTH-1:0] async_in, // Signals from outside the domain
  output wire [WIDTH-1:0] sync_out // Synchronised copies
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // First stage feeds only the second stage
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule // pin_sync

`default_nettype wire

// ===== test/isc_port_props.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Port checker
module isc_port_props (
  input wire logic clock_in, // System clock
  input wire logic reset_n_in, // Async reset
  input wire logic pc1_tck_in, // Link clock pin
  input wire logic chip_reset_n_in, // Chip reset pin
  input wire logic security_bit_in, // Security bit
  input wire logic flash_busy_in, // Flash busy
  input wire logic pc6_tdo_out, // Data-out level
  input wire logic pc6_tdo_oe_out, // Data-out enable
  input wire logic pc3_status_out, // Status level
  input wire logic pc3_status_oe_out, // Status enable
  input wire logic pc4_error_out, // Error level
  input wire logic pc4_error_oe_out, // Error enable
  input wire logic flash_start_out, // Start pulse
  input wire logic [1:0] flash_op_out, // Operation
  input wire logic security_clear_out // Clear pulse
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  logic [7:0] tck_h;
  logic [7:0] crst_h;
  wire err_lo = pc4_error_oe_out & ~pc4_error_out;
  // Pin history covers the synchroniser delay on both pins
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tck_h <= 8'h00;
      crst_h <= 8'h00;
    end else begin
      tck_h <= {tck_h[6:0], pc1_tck_in};
      crst_h <= {crst_h[6:0], chip_reset_n_in};
    end
  end
  property p_start_pulse; flash_start_out |=> !flash_start_out; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_start_tck; flash_start_out |-> |tck_h; endproperty
  a_start_tck: assert property (p_start_tck) else $error("start without link clock");
  property p_busy; flash_busy_in [*3] |-> !(pc3_status_oe_out && pc3_status_out); endproperty
  a_busy: assert property (p_busy) else $error("status high while busy");
  property p_oe_rise; $rose(pc6_tdo_oe_out) |-> !pc1_tck_in; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("data-out enabled off a fall");
  property p_tdo_fall; $changed(pc6_tdo_out) |-> !pc1_tck_in; endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("data-out moved off a fall");
  property p_secured; security_bit_in && $past(security_bit_in, 3) && flash_start_out
    |-> flash_op_out == 2'h3; endproperty
  a_secured: assert property (p_secured) else $error("secured start not chip erase");
  property p_sec_clr; security_clear_out |-> flash_op_out == 2'h3 ##1 !security_clear_out;
  endproperty
  a_sec_clr: assert property (p_sec_clr) else $error("bad security clear");
  property p_err_hold; err_lo ##1 !err_lo |-> (|tck_h) || (|crst_h); endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag dropped alone");
endmodule // isc_port_props
bind isc_port isc_port_props i_props (.clock_in, .reset_n_in, .pc1_tck_in, .chip_reset_n_in,
  .security_bit_in, .flash_busy_in, .pc6_tdo_out, .pc6_tdo_oe_out, .pc3_status_out,
  .pc3_status_oe_out, .pc4_error_out, .pc4_error_oe_out, .flash_start_out, .flash_op_out,
  .security_clear_out);
`default_nettype wire

// ===== test/jtag_host.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Programming controller
module jtag_host (
  output var logic tms_out, // Mode select
  output var logic tck_out, // Link clock
  output var logic tdi_out, // Serial data out
  input wire logic tdo_in, // Serial data in
  input wire logic tdo_oe_in // Data-in driven
);
  // Link clock stands low between frames
  initial begin
    tms_out = 1'b1;
    tck_out = 1'b0;
    tdi_out = 1'b0;
  end
  task automatic step(input logic m, input logic d, output logic q);
    tms_out = m;
    tdi_out = d;
    #62;
    // Released data-out reads as pulled high
    q = tdo_oe_in ? tdo_in : 1'b1;
    tck_out = 1'b1;
    #63;
    tck_out = 1'b0;
  endtask
  task automatic reset_tap;
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
  task automatic scan(input logic ir, input logic [23:0] v, input int n,
      output logic [23:0] r);
    logic q;
    r = 24'h000000;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i], q);
      r[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule // jtag_host
`default_nettype wire

// ===== test/isc_port_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "isc_port_defines.vh"
// ==========
// Bench
module isc_port_tb;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic chip_reset_n_in = 1'b0;
  logic security_bit_in = 1'b0;
  logic [7:0] pri_protect_in = 8'h00;
  logic [3:0] sec_protect_in = 4'h0;
  logic flash_busy_in = 1'b0;
  logic sec_write_in = 1'b0;
  logic flash_done_in = 1'b0;
  logic flash_fail_in = 1'b0;
  logic oe_seen = 1'b0;
  logic [7:0] busy_cnt = 8'h00;
  logic [23:0] starts = 24'h000000;
  logic [23:0] clears = 24'h000000;
  logic [23:0] r;
  logic [23:0] s0;
  int fails = 0;
  int check_count = 0;
  wire pc0_tms_in, pc1_tck_in, pc5_tdi_in, pc6_tdo_out, pc6_tdo_oe_out;
  wire pc3_status_out, pc3_status_oe_out, pc4_error_out, pc4_error_oe_out;
  wire flash_start_out, flash_sec_out, security_clear_out;
  wire [1:0] flash_op_out;
  wire [14:0] flash_addr_out;
  wire [7:0] flash_wdata_out;
  wire st_lvl = pc3_status_oe_out ? pc3_status_out : 1'b1;
  wire er_lvl = pc4_error_oe_out ? pc4_error_out : 1'b1;
  isc_port i_dut (.clock_in, .reset_n_in, .pc0_tms_in, .pc1_tck_in, .pc5_tdi_in, .pc6_tdo_out,
    .pc6_tdo_oe_out, .pc3_status_out, .pc3_status_oe_out, .pc4_error_out, .pc4_error_oe_out,
    .chip_reset_n_in, .security_bit_in, .pri_protect_in, .sec_protect_in,
    .flash_busy_in, .sec_write_in, .flash_done_in, .flash_fail_in,
    .flash_rdata_in(8'h5a), .flash_start_out, .flash_op_out, .flash_sec_out, .flash_addr_out,
    .flash_wdata_out, .security_clear_out);
  jtag_host i_host (.tms_out(pc0_tms_in), .tck_out(pc1_tck_in), .tdi_out(pc5_tdi_in),
    .tdo_in(pc6_tdo_out), .tdo_oe_in(pc6_tdo_oe_out));
  always #4 clock_in = ~clock_in;
  // Flash engine: long enough busy that status is still low when a scan returns
  always @(posedge clock_in) begin
    flash_done_in <= 1'b0;
    if (pc6_tdo_oe_out) oe_seen <= 1'b1;
    if (security_clear_out) clears <= clears + 24'h000001;
    if (flash_start_out) begin
      starts <= starts + 24'h000001;
      busy_cnt <= 8'h3c;
      flash_busy_in <= 1'b1;
    end else if (busy_cnt == 8'h01) begin
      busy_cnt <= 8'h00;
      flash_busy_in <= 1'b0;
      flash_done_in <= 1'b1;
    end else if (busy_cnt != 8'h00) busy_cnt <= busy_cnt - 8'h01;
  end
  task automatic chk(input string w, input logic [23:0] e, input logic [23:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask
  task automatic cb(input string w, input logic e, input logic g);
    chk(w, {23'h0, e}, {23'h0, g});
  endtask
  task automatic ir(input logic [7:0] c);
    i_host.scan(1'b1, {16'h0000, c}, 8, r);
  endtask
  task automatic dr(input logic [23:0] v);
    i_host.scan(1'b0, v, 24, r);
  endtask
  task automatic settle;
    for (int k = 0; k < 200 && busy_cnt != 8'h00; k++) @(posedge clock_in);
    repeat (4) @(posedge clock_in);
  endtask
  task automatic enable(input logic [7:0] o);
    ir(`INS_ENABLE);
    i_host.scan(1'b0, {16'h0000, o}, 8, r);
  endtask
  task automatic t_idle;
    cb("data-out enable", 1'h0, pc6_tdo_oe_out);
    chk("extension enables", 24'h0, {22'h0, pc3_status_oe_out, pc4_error_oe_out});
    ir(`INS_PROGRAM);
    dr(24'h0012a5);
    settle();
    chk("start count", 24'h0, starts);
    cb("data-out driven", 1'h0, oe_seen);
    enable(8'h00);
    chk("extension enables", 24'h0, {22'h0, pc3_status_oe_out, pc4_error_oe_out});
  endtask
  task automatic t_prog;
    enable(8'h01);
    cb("status enable", 1'h1, pc3_status_oe_out);
    cb("status level", 1'h1, st_lvl);
    @(posedge clock_in) sec_write_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    @(negedge clock_in);
    cb("status level", 1'h0, st_lvl);
    @(posedge clock_in) sec_write_in <= 1'b0;
    @(posedge clock_in) flash_fail_in <= 1'b1;
    ir(`INS_PROGRAM);
    dr({1'b0, 15'h2345, 8'ha5});
    chk("start count", 24'h000001, starts);
    chk("op", {22'h0, `OP_PROGRAM}, {22'h0, flash_op_out});
    chk("target", 24'h2345a5, {flash_sec_out, flash_addr_out, flash_wdata_out});
    cb("status level", 1'h0, st_lvl);
    cb("data-out driven", 1'h1, oe_seen);
    settle();
    cb("error level", 1'h0, er_lvl);
    cb("status level", 1'h1, st_lvl);
    ir(`INS_BYPASS);
    cb("error level", 1'h0, er_lvl);
    ir(`INS_CLEAR);
    cb("error level", 1'h1, er_lvl);
  endtask
  task automatic t_read;
    @(posedge clock_in) flash_fail_in <= 1'b0;
    ir(`INS_READ);
    dr(24'h001000);
    chk("first read", 24'h0000ff, {16'h0, r[7:0]});
    settle();
    dr(24'h001000);
    chk("read byte", 24'h00005a, {16'h0, r[7:0]});
    settle();
    @(posedge clock_in) security_bit_in <= 1'b1;
    dr(24'h001000);
    settle();
    dr(24'h001000);
    chk("secured read", {16'h0, `SECURE_READ_BYTE}, {16'h0, r[7:0]});
    settle();
  endtask
  task automatic t_secure;
    ir(`INS_CLEAR);
    s0 = starts;
    ir(`INS_PROGRAM);
    dr(24'h0012a5);
    settle();
    chk("start count", s0, starts);
    cb("error level", 1'h0, er_lvl);
    ir(`INS_CHIP_ERASE);
    dr(24'h000000);
    chk("op", {22'h0, `OP_CHIP}, {22'h0, flash_op_out});
    settle();
    chk("security clears", 24'h000001, clears);
    @(posedge clock_in) security_bit_in <= 1'b0;
  endtask
  task automatic t_prot;
    ir(`INS_CLEAR);
    @(posedge clock_in) pri_protect_in <= 8'h02;
    s0 = starts;
    ir(`INS_ERASE_SECTOR);
    dr(24'h100000);
    settle();
    chk("start count", s0, starts);
    cb("error level", 1'h0, er_lvl);
    @(posedge clock_in) sec_protect_in <= 4'h4;
    dr(24'ha00000);
    settle();
    chk("start count", s0, starts);
    dr(24'h200000);
    chk("op", {22'h0, `OP_SECTOR}, {22'h0, flash_op_out});
    settle();
    chk("start count", s0 + 24'h000001, starts);
    // Error is still low here, which the open-drain check relies on
    enable(8'h03);
    chk("open-drain pins", 24'h000002, {20'h0, pc3_status_oe_out, pc3_status_out,
      pc4_error_oe_out, pc4_error_out});
  endtask
  task automatic t_disable;
    ir(`INS_DISABLE);
    s0 = starts;
    ir(`INS_PROGRAM);
    dr(24'h0012a5);
    settle();
    chk("start count", s0, starts);
    enable(8'h01);
    cb("error level", 1'h0, er_lvl);
    ir(`INS_DISABLE);
    @(posedge clock_in) chip_reset_n_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    chip_reset_n_in <= 1'b0;
    repeat (8) @(posedge clock_in);
    enable(8'h01);
    cb("error level", 1'h1, er_lvl);
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    i_host.reset_tap();
    t_idle();
    t_prog();
    t_read();
    t_secure();
    t_prot();
    t_disable();
    test_done();
  end
  initial begin
    #400000;
    fails++;
    test_done();
  end
endmodule // isc_port_tb
`default_nettype wire
